// ===== hw/emi_ctrl.sv
`timescale 1ns/1ns
module emi_ctrl
  import emi_pkg::*;
#(
  parameter int ONCHIP_AW = 13
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  timing_rdata,
  input  wire logic [7:0]  ext_mem_config,
  input  wire logic [7:0]  ext_data_bank_page,
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic        acc_wide,
  input  wire logic [7:0]  indirect_addr,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  acc_wdata,
  output logic             acc_done,
  output logic      [7:0]  acc_rdata,
  output logic             acc_busy,
  output logic      [15:0] addr_o,
  output logic             addr_hi_oe,
  output logic             addr_lo_oe,
  output logic      [7:0]  data_o,
  output logic             data_oe,
  input  wire logic [7:0]  data_i,
  output logic             rd_n,
  output logic             wr_n,
  output logic             ale
);
`include "emi_params.svh"

  // ==========================================
  // Timing register
  logic [7:0] tc_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tc_q <= `EMI_TC_RESET;
    end else if (reg_wr && reg_addr == `EMI_TC_ADDR) begin
      tc_q <= reg_wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      timing_rdata <= `EMI_TC_RESET;
    end else begin
      timing_rdata <= tc_q;
    end
  end

  // ==========================================
  // Pin synchroniser for read data
  logic [7:0] din_s1_q;
  logic [7:0] din_s2_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
    end else begin
      din_s1_q <= data_i;
      din_s2_q <= din_s1_q;
    end
  end

  // ==========================================
  // Address formation and routing
  logic [1:0]  mode;
  logic        mux_mode;
  logic [15:0] eff_addr;
  logic        off_chip;
  logic        drive_hi;
  assign mode     = ext_mem_config[`EMI_CF_MODE_HI:`EMI_CF_MODE_LO];
  assign mux_mode = ext_mem_config[`EMI_CF_MUX_BIT];
  assign eff_addr = acc_wide ? data_pointer
                             : {ext_data_bank_page, indirect_addr};
  always_comb begin
    if (mode == `EMI_MODE_EXT_ONLY) begin
      off_chip = 1'b1;
      drive_hi = acc_wide;
    end else if (mode == `EMI_MODE_SPLIT_BANK) begin
      off_chip = {1'b0, eff_addr} >= `EMI_ONCHIP_LIMIT;
      drive_hi = 1'b1;
    end else begin
      off_chip = 1'b0;
      drive_hi = 1'b1;
    end
  end

  // ==========================================
  // On-chip RAM path
  logic       ram_we;
  logic [7:0] ram_rdata;
  logic       ram_pend_q;
  assign ram_we = acc_req && !acc_busy && !off_chip && acc_write;
  emi_ram #(.AW(ONCHIP_AW), .DW(8)) u_ram (
    .clk   (clk),
    .we    (ram_we),
    .addr  (eff_addr[ONCHIP_AW-1:0]),
    .wdata (acc_wdata),
    .rdata (ram_rdata)
  );

  // ==========================================
  // Off-chip sequencer
  emi_state_t state_q;
  logic [4:0] cnt_q;
  logic       wr_q;
  logic [1:0] ale_len;
  assign ale_len = ext_mem_config[`EMI_CF_ALE_HI:`EMI_CF_ALE_LO];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q    <= EMI_IDLE;
      cnt_q      <= 5'h00;
      wr_q       <= 1'b0;
      ram_pend_q <= 1'b0;
    end else begin
      ram_pend_q <= 1'b0;
      case (state_q)
        EMI_IDLE: begin
          if (acc_req && off_chip) begin
            wr_q <= acc_write;
            if (mux_mode) begin
              state_q <= EMI_ALE;
              cnt_q   <= 5'(ale_len) + 5'(`EMI_ALE_MIN_CYCLES - 1);
            end else begin
              state_q <= EMI_SETUP;
              cnt_q   <= 5'(tc_q[`EMI_TC_SETUP_HI:`EMI_TC_SETUP_LO]);
            end
          end else if (acc_req) begin
            ram_pend_q <= 1'b1;
            state_q    <= EMI_DONE;
          end
        end
        EMI_ALE: begin
          if (cnt_q == 5'h00) begin
            state_q <= EMI_SETUP;
            cnt_q   <= 5'(tc_q[`EMI_TC_SETUP_HI:`EMI_TC_SETUP_LO]);
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        EMI_SETUP: begin
          if (cnt_q == 5'h00) begin
            state_q <= EMI_STROBE;
            cnt_q   <= 5'(tc_q[`EMI_TC_WIDTH_HI:`EMI_TC_WIDTH_LO]);
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        EMI_STROBE: begin
          if (cnt_q == 5'h00) begin
            state_q <= EMI_HOLD;
            cnt_q   <= 5'(tc_q[`EMI_TC_HOLD_HI:`EMI_TC_HOLD_LO]);
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        EMI_HOLD: begin
          if (cnt_q == 5'h00) begin
            state_q <= EMI_FIXED;
            // Base setup, base hold, this cycle and done make the fixed four
            cnt_q   <= 5'(`EMI_FIXED_CYCLES - 4);
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        EMI_FIXED: begin
          if (cnt_q == 5'h00) begin
            state_q <= EMI_DONE;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        EMI_DONE: begin
          state_q <= EMI_IDLE;
        end
        default: begin
          state_q <= EMI_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Pin outputs
  logic in_access;
  logic strobe_d;
  logic ale_d;
  assign in_access = acc_req && off_chip && state_q == EMI_IDLE;
  assign strobe_d  = (state_q == EMI_SETUP && cnt_q == 5'h00)
                  || (state_q == EMI_STROBE && cnt_q != 5'h00);
  assign ale_d     = (in_access && mux_mode) || (state_q == EMI_ALE && cnt_q != 5'h00);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      addr_o     <= 16'h0000;
      addr_hi_oe <= 1'b0;
      addr_lo_oe <= 1'b0;
      data_o     <= 8'h00;
      data_oe    <= 1'b0;
      rd_n       <= 1'b1;
      wr_n       <= 1'b1;
      ale        <= 1'b0;
    end else begin
      if (in_access) begin
        addr_o     <= eff_addr;
        addr_hi_oe <= drive_hi;
        addr_lo_oe <= 1'b1;
        data_o     <= acc_wdata;
      end else if (state_q == EMI_FIXED || state_q == EMI_DONE) begin
        addr_hi_oe <= 1'b0;
        addr_lo_oe <= 1'b0;
      end
      ale     <= ale_d;
      rd_n    <= !(strobe_d && !wr_q);
      wr_n    <= !(strobe_d && wr_q);
      data_oe <= wr_q && (strobe_d || state_q == EMI_SETUP);
    end
  end

  // ==========================================
  // Completion and read capture
  logic rd_end_q;
  logic rd_cap_q;
  // Pin data seen at the last strobe edge leaves the synchroniser two cycles later
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_end_q <= 1'b0;
      rd_cap_q <= 1'b0;
    end else begin
      rd_end_q <= state_q == EMI_STROBE && cnt_q == 5'h00 && !wr_q;
      rd_cap_q <= rd_end_q;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_done  <= 1'b0;
      acc_rdata <= 8'h00;
      acc_busy  <= 1'b0;
    end else begin
      acc_done <= state_q == EMI_DONE;
      acc_busy <= acc_req || (state_q != EMI_IDLE && state_q != EMI_DONE);
      if (rd_cap_q) begin
        acc_rdata <= din_s2_q;
      end else if (ram_pend_q) begin
        acc_rdata <= ram_rdata;
      end
    end
  end
endmodule

// ===== hw/emi_params.svh
`ifndef EMI_PARAMS_SVH
`define EMI_PARAMS_SVH
// ==========================================
// Register map
`define EMI_TC_ADDR        8'hA1
`define EMI_TC_RESET       8'hFF
`define EMI_CF_RESET       8'h00
`define EMI_BANK_RESET     8'h00
// ==========================================
// Field positions
`define EMI_TC_SETUP_HI    7
`define EMI_TC_SETUP_LO    6
`define EMI_TC_WIDTH_HI    5
`define EMI_TC_WIDTH_LO    2
`define EMI_TC_HOLD_HI     1
`define EMI_TC_HOLD_LO     0
`define EMI_CF_MODE_HI     3
`define EMI_CF_MODE_LO     2
`define EMI_CF_MUX_BIT     4
`define EMI_CF_ALE_HI      1
`define EMI_CF_ALE_LO      0
// ==========================================
// Modes and timing
`define EMI_MODE_SPLIT_BANK 2'b10
`define EMI_MODE_EXT_ONLY   2'b11
`define EMI_ONCHIP_LIMIT    17'h02000
`define EMI_FIXED_CYCLES    4
`define EMI_ALE_MIN_CYCLES  2
`endif

// ===== hw/emi_pkg.sv
package emi_pkg;
  typedef enum logic [6:0] {
    EMI_IDLE   = 7'h01,
    EMI_ALE    = 7'h02,
    EMI_SETUP  = 7'h04,
    EMI_STROBE = 7'h08,
    EMI_HOLD   = 7'h10,
    EMI_FIXED  = 7'h20,
    EMI_DONE   = 7'h40
  } emi_state_t;
endpackage

// ===== hw/emi_ram.sv
`timescale 1ns/1ns
// ==========================================
// On-chip data RAM with registered read
module emi_ram #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ===== sim/emi_ctrl_properties.sv
`timescale 1ns/1ns
// ==========================================
// Port checker for the access sequencer
module emi_ctrl_properties (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [7:0]  timing_rdata,
  input wire logic [7:0]  ext_mem_config,
  input wire logic [7:0]  ext_data_bank_page,
  input wire logic        acc_req,
  input wire logic        acc_wide,
  input wire logic [7:0]  indirect_addr,
  input wire logic [15:0] data_pointer,
  input wire logic [15:0] addr_o,
  input wire logic        addr_hi_oe,
  input wire logic        addr_lo_oe,
  input wire logic [7:0]  data_o,
  input wire logic        data_oe,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        ale
);
  logic [4:0] stb_q;
  logic [2:0] su_q;
  wire        idle = rd_n & wr_n;
  wire        act  = !idle && !ext_mem_config[4];
  wire [1:0]  md   = ext_mem_config[3:2];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Strobe length counter
  always_ff @(posedge clk) begin
    stb_q <= (!resetn || idle) ? 5'h00 : stb_q + 5'h01;
  end
  // Cycles from address drive to strobe
  always_ff @(posedge clk) begin
    su_q <= (!resetn || !addr_lo_oe) ? 3'h0 : su_q + 3'h1;
  end
  a_strobe_width: assert property ($rose(idle) |-> stb_q == {1'b0, timing_rdata[5:2]} + 5'h01)
    else $error("strobe width wrong");
  a_setup_time: assert property ($fell(idle) && !ext_mem_config[4] |-> su_q == {1'b0, timing_rdata[7:6]} + 3'h1)
    else $error("address setup wrong");
  a_bank_addr: assert property (act && md == 2'b10 && !acc_wide |-> addr_hi_oe && addr_o == {ext_data_bank_page, indirect_addr})
    else $error("banked address wrong");
  a_ptr_addr: assert property (act && ext_mem_config[3] && acc_wide |-> addr_hi_oe && addr_o == data_pointer)
    else $error("pointer address wrong");
  a_ext_hi_float: assert property (act && md == 2'b11 && !acc_wide |-> !addr_hi_oe && addr_lo_oe && addr_o[7:0] == indirect_addr)
    else $error("upper address driven");
  a_onchip_quiet: assert property (acc_req && (!md[1] || md == 2'b10 && (acc_wide ? data_pointer < 16'h2000 : ext_data_bank_page < 8'h20)) |-> idle)
    else $error("on-chip access strobed");
  a_write_drive: assert property (!wr_n |-> data_oe ##1 (wr_n || $stable(data_o)))
    else $error("write data not held");
  a_ale_pulse: assert property ($rose(ale) |-> ext_mem_config[4] ##0 ale[*2])
    else $error("latch strobe short");
  c_write: cover property (!wr_n);
  c_latch: cover property ($rose(ale));
  c_float: cover property (!idle && !addr_hi_oe);
endmodule
bind emi_ctrl emi_ctrl_properties u_props (.*);

// ===== sim/emi_ext_mem.sv
`timescale 1ns/1ns
// ==========================================
// Off-chip asynchronous byte memory
module emi_ext_mem (
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        sel,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [0:65535];
  logic       rd_q;
  initial begin
    rd_q = 1'b0;
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h00;
  end
  always @(posedge wr_n) mem[addr] = wdata;
  always @(negedge rd_n) rd_q = 1'b1;
  always @(negedge sel) rd_q = 1'b0;
  // Released bus shows the inverse pattern
  assign rdata = rd_q ? mem[addr] : ~mem[addr];
endmodule

// ===== sim/external_memory_interface_bench.sv
`timescale 1ns/1ns
module external_memory_interface_bench;
  logic        clk, resetn, reg_wr, acc_req, acc_write, acc_wide, acc_done, acc_busy;
  logic        addr_hi_oe, addr_lo_oe, data_oe, rd_n, wr_n, ale;
  logic [7:0]  reg_addr, reg_wdata, timing_rdata, ext_mem_config, ext_data_bank_page;
  logic [7:0]  indirect_addr, acc_wdata, acc_rdata, data_o, data_i;
  logic [15:0] data_pointer, addr_o, pin_addr;
  int          num_errors, cmp_count, n0, n;
  // Undriven upper lines read as the fixed value 8'h5A
  assign pin_addr = {addr_hi_oe ? addr_o[15:8] : 8'h5A, addr_o[7:0]};
  emi_ctrl u_dut (.*);
  emi_ext_mem u_mem (.addr(pin_addr), .wdata(data_o), .rd_n(rd_n), .wr_n(wr_n),
                     .sel(addr_lo_oe), .rdata(data_i));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // ==========================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic xfer(input logic w, wd, input logic [15:0] a, input logic [7:0] d,
                      output int k);
    @(negedge clk);
    acc_write = w;
    acc_wide = wd;
    data_pointer = a;
    ext_data_bank_page = a[15:8];
    indirect_addr = a[7:0];
    acc_wdata = d;
    acc_req = 1'b1;
    k = 0;
    while (acc_done !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk({7'h00, acc_busy}, 8'h01);
    acc_req = 1'b0;
    if (k == 200) chk(8'h00, 8'h01);
  endtask
  task automatic dur(input logic [7:0] tc, input int extra);
    int k;
    reg_write(8'hA1, tc);
    xfer(1'b0, 1'b1, 16'h4000, 8'h00, k);
    chk(8'(k - n0), 8'(extra));
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    {resetn, reg_wr, acc_req, acc_write, acc_wide} = 5'h00;
    {reg_addr, reg_wdata, indirect_addr, acc_wdata, ext_data_bank_page} = 40'h0;
    data_pointer = 16'h0000;
    ext_mem_config = 8'h08;
    num_errors = 0;
    cmp_count = 0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    reg_write(8'hA2, 8'h00);
    @(negedge clk);
    chk(timing_rdata, 8'hFF);
    reg_write(8'hA1, 8'h00);
    @(negedge clk);
    chk(timing_rdata, 8'h00);
    xfer(1'b1, 1'b1, 16'h4234, 8'hA5, n0);
    chk(u_mem.mem[16'h4234], 8'hA5);
    chk(8'(n0), 8'h06);
    xfer(1'b0, 1'b1, 16'h4234, 8'h00, n);
    chk(acc_rdata, 8'hA5);
    xfer(1'b1, 1'b1, 16'h0100, 8'h3C, n);
    chk(u_mem.mem[16'h0100], 8'h00);
    xfer(1'b0, 1'b1, 16'h0100, 8'h00, n);
    chk(acc_rdata, 8'h3C);
    xfer(1'b1, 1'b0, 16'h4021, 8'h77, n);
    chk(u_mem.mem[16'h4021], 8'h77);
    xfer(1'b1, 1'b0, 16'h0021, 8'h66, n);
    chk(u_mem.mem[16'h0021], 8'h00);
    ext_mem_config = 8'h0C;
    xfer(1'b0, 1'b1, 16'h0100, 8'h00, n);
    chk(acc_rdata, 8'h00);
    xfer(1'b1, 1'b0, 16'h1234, 8'h99, n);
    chk(u_mem.mem[16'h5A34], 8'h99);
    xfer(1'b1, 1'b1, 16'h0021, 8'h11, n);
    chk(u_mem.mem[16'h0021], 8'h11);
    dur(8'h4E, 6);
    dur(8'h83, 5);
    dur(8'hFF, 21);
    ext_mem_config = 8'h1C;
    dur(8'h00, 2);
    ext_mem_config = 8'h1D;
    dur(8'h00, 3);
    ext_mem_config = 8'h00;
    xfer(1'b0, 1'b1, 16'h4100, 8'h00, n);
    chk(acc_rdata, 8'h3C);
    tally_and_finish();
  end
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule
